// ---- include/issf_defs.vh ----
// Register map, field positions and reset values of the stop-flag block
`ifndef ISSF_DEFS_VH
`define ISSF_DEFS_VH

// ====================================================================
// Register byte offsets
`define ISSF_OFS_CTRL_STATUS 8'h00
`define ISSF_OFS_CONTROL     8'h04
`define ISSF_OFS_INT_STATUS  8'h08
`define ISSF_OFS_INT_MASK    8'h0C
`define ISSF_OFS_LINK_STATE  8'h10

// ====================================================================
// Flag and acknowledge register fields
`define ISSF_CS_WIDTH        8
`define ISSF_CS_ERROR_STOP   7
`define ISSF_CS_NORMAL_STOP  6
`define ISSF_CS_RESET        8'h00

// ====================================================================
// Control register fields
`define ISSF_CTL_SLAVE_MODE  0
`define ISSF_CTL_RESET       8'h00

// ====================================================================
// Interrupt status and mask fields
`define ISSF_INT_WIDTH       3
`define ISSF_INT_XFER        0
`define ISSF_INT_ERR_EVT     1
`define ISSF_INT_NORM_EVT    2
`define ISSF_INT_RESET       3'h0
`define ISSF_MASK_RESET      3'h0

// ====================================================================
// Link state register fields
`define ISSF_LS_FRAME_BUSY   0
`define ISSF_LS_SLAVE_MODE   1

`endif

// ---- hw/issf_stop_flags.v ----
// Stop-condition status flags of an I2C slave with APB register access
//
// Our own choices: the APB register port and the register addresses.

`include "issf_defs.vh"

// ====================================================================
// Read-then-write-zero sticky flag
module issf_rdclr_flag (
  input wire core_clk,
  input wire reset,
  input wire set_evt,
  input wire rd_one,
  input wire wr_acc,
  input wire wr_bit,
  input wire hw_clear,
  output wire flag
);

  reg flag_r;
  reg flag_nxt;
  reg arm_r;
  reg arm_nxt;
  wire sw_clear;

  assign sw_clear = wr_acc && !wr_bit && arm_r;

  always @* begin
    flag_nxt = flag_r;
    if (sw_clear) begin
      flag_nxt = 1'b0;
    end
    if (hw_clear) begin
      flag_nxt = 1'b0;
    end
    if (set_evt) begin
      flag_nxt = 1'b1;
    end
  end

  // Arm is lost on any write to the flag register, so a stale read cannot clear a new event
  always @* begin
    arm_nxt = arm_r;
    if (wr_acc) begin
      arm_nxt = 1'b0;
    end
    if (!flag_nxt) begin
      arm_nxt = 1'b0;
    end
    if (rd_one) begin
      arm_nxt = 1'b1;
    end
  end

  always @(posedge core_clk) begin
    if (reset) begin
      flag_r <= 1'b0;
      arm_r <= 1'b0;
    end else begin
      flag_r <= flag_nxt;
      arm_r <= arm_nxt;
    end
  end

  assign flag = flag_r;

endmodule

// ====================================================================
// Top level
module issf_stop_flags (
  input wire core_clk,
  input wire reset,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire stop_detect,
  input wire frame_busy,
  output wire irq
);

  // ==================================================================
  // Bus phase decode
  wire setup_ph;
  wire access_done;
  wire wr_done;
  wire rd_done;
  wire hit_cs;
  wire hit_ctl;
  wire hit_ist;
  wire hit_msk;
  wire hit_ls;
  wire hit_any;
  // Captured in the setup cycle, used in the access cycle
  reg err_r;

  assign setup_ph = psel && !penable;
  assign access_done = psel && penable;
  assign wr_done = access_done && pwrite && !err_r;
  assign rd_done = access_done && !pwrite && !err_r;

  assign hit_cs = (paddr == `ISSF_OFS_CTRL_STATUS);
  assign hit_ctl = (paddr == `ISSF_OFS_CONTROL);
  assign hit_ist = (paddr == `ISSF_OFS_INT_STATUS);
  assign hit_msk = (paddr == `ISSF_OFS_INT_MASK);
  assign hit_ls = (paddr == `ISSF_OFS_LINK_STATE);
  assign hit_any = hit_cs || hit_ctl || hit_ist || hit_msk || hit_ls;

  // ==================================================================
  // Write strobes
  wire ctl_wr;
  wire ist_wr;
  wire msk_wr;

  assign ctl_wr = wr_done && hit_ctl;
  assign ist_wr = wr_done && hit_ist;
  assign msk_wr = wr_done && hit_msk;

  // ==================================================================
  // Software registers
  reg [7:0] ctl_r;
  reg [`ISSF_INT_WIDTH-1:0] int_st_r;
  reg [`ISSF_INT_WIDTH-1:0] int_st_nxt;
  reg [7:0] ctl_nxt;
  reg [`ISSF_INT_WIDTH-1:0] int_msk_r;
  reg [`ISSF_INT_WIDTH-1:0] int_msk_nxt;
  reg rd_err_stop_r;
  reg rd_norm_stop_r;

  wire slave_mode;
  wire err_stop;
  wire norm_stop;
  wire [7:0] cs_value;

  assign slave_mode = ctl_r[`ISSF_CTL_SLAVE_MODE];

  // ==================================================================
  // Stop classification
  wire err_set;
  wire norm_set;
  wire xfer_clr;
  wire stop_in_mode;

  assign stop_in_mode = slave_mode && stop_detect;
  assign err_set = stop_in_mode && frame_busy;
  assign norm_set = stop_in_mode && !frame_busy;

  // Software clear of the transfer interrupt flag
  assign xfer_clr = ist_wr && pwdata[`ISSF_INT_XFER];

  // ==================================================================
  // Stop flags
  wire cs_wr;
  wire cs_rd;

  assign cs_wr = wr_done && hit_cs;
  assign cs_rd = rd_done && hit_cs;

  // ==================================================================
  // Read arm
  wire err_rd_one;
  wire norm_rd_one;

  // Arm only from the value that the read returned
  assign err_rd_one = cs_rd && rd_err_stop_r;
  assign norm_rd_one = cs_rd && rd_norm_stop_r;

  issf_rdclr_flag u_err_flag (
    .core_clk(core_clk),
    .reset(reset),
    .set_evt(err_set),
    .rd_one(err_rd_one),
    .wr_acc(cs_wr),
    .wr_bit(pwdata[`ISSF_CS_ERROR_STOP]),
    .hw_clear(xfer_clr),
    .flag(err_stop)
  );

  issf_rdclr_flag u_norm_flag (
    .core_clk(core_clk),
    .reset(reset),
    .set_evt(norm_set),
    .rd_one(norm_rd_one),
    .wr_acc(cs_wr),
    .wr_bit(pwdata[`ISSF_CS_NORMAL_STOP]),
    .hw_clear(xfer_clr),
    .flag(norm_stop)
  );

  assign cs_value = {err_stop, norm_stop, 6'h00};

  // ==================================================================
  // Link state view
  wire [7:0] ls_value;

  assign ls_value = {6'h00, slave_mode, frame_busy};

  // ==================================================================
  // Interrupt status, set wins over clear
  always @* begin
    int_st_nxt = int_st_r;
    if (ist_wr) begin
      int_st_nxt = int_st_r & ~pwdata[`ISSF_INT_WIDTH-1:0];
    end
    if (err_set || norm_set) begin
      int_st_nxt[`ISSF_INT_XFER] = 1'b1;
    end
    if (err_set) begin
      int_st_nxt[`ISSF_INT_ERR_EVT] = 1'b1;
    end
    if (norm_set) begin
      int_st_nxt[`ISSF_INT_NORM_EVT] = 1'b1;
    end
  end

  always @(posedge core_clk) begin
    if (reset) begin
      ctl_r <= `ISSF_CTL_RESET;
      int_st_r <= `ISSF_INT_RESET;
      int_msk_r <= `ISSF_MASK_RESET;
    end else begin
      int_st_r <= int_st_nxt;
      ctl_r <= ctl_nxt;
      int_msk_r <= int_msk_nxt;
    end
  end

  assign irq = |(int_st_r & int_msk_r);

  // ==================================================================
  // Control and mask next values
  // Only the mode bit is kept, so reserved bits always read zero
  always @* begin
    ctl_nxt = ctl_r;
    if (ctl_wr) begin
      ctl_nxt = {7'h00, pwdata[`ISSF_CTL_SLAVE_MODE]};
    end
  end

  always @* begin
    int_msk_nxt = int_msk_r;
    if (msk_wr) begin
      int_msk_nxt = pwdata[`ISSF_INT_WIDTH-1:0];
    end
  end

  // ==================================================================
  // Read data and error, captured in the setup cycle
  // Flag value seen by software is the one latched here, so the arm
  // follows exactly what the read returned
  reg [31:0] rd_mux;
  reg [31:0] prdata_nxt;
  reg err_nxt;
  reg rd_err_stop_nxt;
  reg rd_norm_stop_nxt;

  always @* begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      `ISSF_OFS_CTRL_STATUS: begin
        rd_mux = {24'h00_0000, cs_value};
      end
      `ISSF_OFS_CONTROL: begin
        rd_mux = {24'h00_0000, ctl_r};
      end
      `ISSF_OFS_INT_STATUS: begin
        rd_mux = {29'h0000_0000, int_st_r};
      end
      `ISSF_OFS_INT_MASK: begin
        rd_mux = {29'h0000_0000, int_msk_r};
      end
      `ISSF_OFS_LINK_STATE: begin
        rd_mux = {24'h00_0000, ls_value};
      end
      default: begin
        rd_mux = 32'h0000_0000;
      end
    endcase
  end

  // Everything here moves only in a setup cycle
  always @* begin
    prdata_nxt = prdata;
    err_nxt = err_r;
    rd_err_stop_nxt = rd_err_stop_r;
    rd_norm_stop_nxt = rd_norm_stop_r;
    if (setup_ph) begin
      prdata_nxt = 32'h0000_0000;
      if (!pwrite) begin
        prdata_nxt = rd_mux;
      end
      err_nxt = !hit_any;
      rd_err_stop_nxt = err_stop;
      rd_norm_stop_nxt = norm_stop;
    end
  end

  always @(posedge core_clk) begin
    if (reset) begin
      prdata <= 32'h0000_0000;
      err_r <= 1'b0;
      rd_err_stop_r <= 1'b0;
      rd_norm_stop_r <= 1'b0;
    end else begin
      prdata <= prdata_nxt;
      err_r <= err_nxt;
      rd_err_stop_r <= rd_err_stop_nxt;
      rd_norm_stop_r <= rd_norm_stop_nxt;
    end
  end

  // ==================================================================
  // Bus answer
  // Zero wait states: every access ends in its first access cycle
  assign pready = psel && penable;
  assign pslverr = access_done && err_r;

endmodule

// ---- tb/issf_stop_flags_assertions.sv ----
// Port checker of the stop-flag block
module issf_stop_flags_assertions (
  input wire core_clk,
  input wire reset,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire stop_detect,
  input wire irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  sequence s_acc;
    psel && penable;
  endsequence
  // Set wins, so only a quiet clear
  sequence s_clr_all;
    s_acc ##0 pwrite && paddr == 8'h08 && pwdata[2:0] == 3'h7 && !stop_detect;
  endsequence
  a_reset_clear: assert property ($fell(reset) |-> prdata == 0 && !irq)
    else $error("not clear after reset");
  a_ready_zero_wait: assert property (pready == (psel && penable))
    else $error("pready wrong");
  a_upper_zero: assert property (prdata[31:8] == 24'h00_0000)
    else $error("upper bits set");
  a_rdata_hold: assert property (!(psel && !penable) |=> $stable(prdata))
    else $error("prdata moved");
  a_unmapped_err: assert property (s_acc ##0 paddr > 8'h10 |-> pslverr)
    else $error("no pslverr");
  a_err_in_access: assert property (pslverr |-> s_acc)
    else $error("stray pslverr");
  a_clear_irq_low: assert property (s_clr_all |=> !irq)
    else $error("irq after clear");
  a_irq_cause: assert property ($rose(irq) |-> $past(stop_detect || pwrite && psel))
    else $error("irq without cause");
endmodule

bind issf_stop_flags issf_stop_flags_assertions u_chk (
  .core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .stop_detect(stop_detect), .irq(irq)
);

// ---- tb/issf_i2c_master.sv ----
// Model of the external bus master ending frames
module issf_i2c_master (
  input wire core_clk,
  output logic stop_detect,
  output logic frame_busy
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    stop_detect = 1'b0;
    frame_busy = 1'b0;
  end
  // ====================================================================
  // Stop pulse in or after a frame
  task stop(input logic busy);
    @(posedge core_clk);
    stop_detect <= 1'b1;
    frame_busy <= busy;
    @(posedge core_clk);
    stop_detect <= 1'b0;
    frame_busy <= 1'b0;
  endtask
endmodule

// ---- tb/tb_i2c_slave_stop_status_flags.sv ----
// Self-checking bench of the stop-flag block
module tb_i2c_slave_stop_status_flags;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] rd;
  logic err;
  wire [31:0] prdata;
  wire pready, pslverr, stop_detect, frame_busy, irq;
  int error_cnt = 0;
  int checks = 0;
  issf_stop_flags DUT (.core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .stop_detect(stop_detect), .frame_busy(frame_busy), .irq(irq));
  issf_i2c_master M (.core_clk(core_clk), .stop_detect(stop_detect), .frame_busy(frame_busy));
  initial forever #50 core_clk = ~core_clk;
  // ====================================================================
  // Shared tasks
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s exp %h got %h", n, e, g);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk("rdata", e, rd);
  endtask
  // Irq settles after the write edge
  task chk_irq(input logic e);
    @(negedge core_clk);
    chk("irq", {31'h0000_0000, e}, {31'h0000_0000, irq});
  endtask
  // ====================================================================
  // Scenarios
  task t_reset_map;
    rdc(8'h00, 32'h0000_0000);
    apb(1'b1, 8'h00, 32'h0000_00FF);
    rdc(8'h00, 32'h0000_0000);
    apb(1'b0, 8'h20, 32'h0000_0000);
    chk("pslverr", 32'h0000_0001, {31'h0000_0000, err});
    chk("rdata", 32'h0000_0000, rd);
  endtask
  task t_error_stop;
    apb(1'b1, 8'h04, 32'h0000_0001);
    apb(1'b1, 8'h0C, 32'h0000_0007);
    M.stop(1'b1);
    apb(1'b1, 8'h00, 32'h0000_0000);
    rdc(8'h00, 32'h0000_0080);
    chk_irq(1'b1);
    apb(1'b1, 8'h00, 32'h0000_0080);
    rdc(8'h00, 32'h0000_0080);
    apb(1'b1, 8'h00, 32'h0000_0000);
    rdc(8'h00, 32'h0000_0000);
    apb(1'b1, 8'h08, 32'h0000_0007);
    chk_irq(1'b0);
  endtask
  task t_normal_stop;
    M.stop(1'b0);
    apb(1'b1, 8'h00, 32'h0000_0000);
    rdc(8'h00, 32'h0000_0040);
    apb(1'b1, 8'h00, 32'h0000_0000);
    rdc(8'h00, 32'h0000_0000);
  endtask
  task t_irq_flag_clear;
    M.stop(1'b1);
    M.stop(1'b0);
    rdc(8'h00, 32'h0000_00C0);
    apb(1'b1, 8'h08, 32'h0000_0001);
    rdc(8'h00, 32'h0000_0000);
    chk_irq(1'b1);
    apb(1'b1, 8'h08, 32'h0000_0007);
    chk_irq(1'b0);
  endtask
  task t_mode_off;
    apb(1'b1, 8'h04, 32'h0000_0000);
    M.stop(1'b1);
    rdc(8'h00, 32'h0000_0000);
    rdc(8'h10, 32'h0000_0000);
    chk_irq(1'b0);
  endtask
  task t_mid_reset;
    apb(1'b1, 8'h04, 32'h0000_0001);
    rdc(8'h04, 32'h0000_0001);
    rdc(8'h10, 32'h0000_0002);
    rdc(8'h0C, 32'h0000_0007);
    M.stop(1'b1);
    rdc(8'h00, 32'h0000_0080);
    chk_irq(1'b1);
    @(posedge core_clk);
    reset <= 1'b1;
    repeat (4) @(posedge core_clk);
    reset <= 1'b0;
    rdc(8'h00, 32'h0000_0000);
    rdc(8'h04, 32'h0000_0000);
    chk_irq(1'b0);
  endtask
  task end_of_test;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Hang guard, well above the run length
  initial begin
    repeat (3000) @(posedge core_clk);
    error_cnt++;
    end_of_test();
  end
  initial begin
    repeat (16) @(posedge core_clk);
    reset <= 1'b0;
    t_reset_map();
    t_error_stop();
    t_normal_stop();
    t_irq_flag_clear();
    t_mode_off();
    t_mid_reset();
    end_of_test();
  end
endmodule
